/* hw/msc_pkg.sv */
package msc_pkg;
   // Clock and base tick
   localparam int unsigned CLK_HZ         = 10000000;
   localparam int unsigned TICK_MS        = 10;
   localparam int unsigned TICK_CYC       = CLK_HZ / 1000 * TICK_MS;
   // Timer units, in 10 ms ticks
   localparam int unsigned STEP_50MS_TK   = 5;
   localparam int unsigned SEC_TK         = 100;
   localparam int unsigned MIN_TK         = 6000;
   localparam int unsigned HOUR_TK        = 360000;
   localparam int unsigned DAYS3_TK       = 25920000;
   localparam int unsigned STEP_5S_TK     = 500;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL        = 8'h00;
   localparam logic [7:0] REG_TSENS       = 8'h04;
   localparam logic [7:0] REG_TESPE       = 8'h08;
   localparam logic [7:0] REG_TMUTE       = 8'h0C;
   localparam logic [7:0] REG_TDEL        = 8'h10;
   localparam logic [7:0] REG_TMDO        = 8'h14;
   localparam logic [7:0] REG_STAT        = 8'h18;
   // CTRL fields
   localparam int unsigned CTRL_MODE_BIT  = 0;
   localparam int unsigned CTRL_OVR_BIT   = 1;
   localparam int unsigned CTRL_DIS_BIT   = 2;
   localparam int unsigned CTRL_MON_BIT   = 3;
   localparam int unsigned CTRL_CUR_BIT   = 4;
   localparam int unsigned CTRL_CUR2_BIT  = 5;
   // TMUTE fields: value in [5:0], unit in [9:8]
   localparam int unsigned TMUTE_UNIT_LSB = 8;
   // Reset values
   localparam logic [5:0]  CTRL_RST       = 6'h1A;
   localparam logic [7:0]  TSENS_RST      = 8'h50;
   localparam logic [7:0]  TESPE_RST      = 8'h64;
   localparam logic [9:0]  TMUTE_RST      = 10'h105;
   localparam logic [7:0]  TDEL_RST       = 8'h05;
   localparam logic [7:0]  TMDO_RST       = 8'h01;
   typedef enum logic [1:0] {MSC_U_SEC, MSC_U_MIN, MSC_U_HOUR, MSC_U_3DAY} msc_unit_e;
endpackage : msc_pkg

/* hw/msc_offdelay.sv */
`timescale 1ns/1ns
`default_nettype none
module msc_offdelay
   import msc_pkg::*;
#(
   parameter int unsigned N = 5
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         tick_i,
   input  wire logic [7:0]   delay_i,
   input  wire logic [N-1:0] raw_i,
   output logic      [N-1:0] held_o
);
   // Each input stays active for delay_i ticks after it drops
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ch
         logic [7:0] cnt_r;
         wire        run = (cnt_r != 8'h00);
         always_ff @(posedge clk_i) begin
            if (rst_i)
               cnt_r <= 8'h00;
            else if (raw_i[g])
               cnt_r <= delay_i;
            else if (tick_i && run)
               cnt_r <= cnt_r - 8'h01;
         end
         assign held_o[g] = raw_i[g] | run;
      end
   endgenerate
endmodule : msc_offdelay
`default_nettype wire

/* hw/msc_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module msc_timer (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        tick_i,
   input  wire logic        run_i,
   input  wire logic [31:0] limit_i,
   output logic             expired_o
);
   // Counts ticks while run_i is high; clears when it falls
   logic [31:0] cnt_r;
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i)
         cnt_r <= 32'h0;
      else if (tick_i && cnt_r < limit_i)
         cnt_r <= cnt_r + 32'h1;
   end
   assign expired_o = run_i && (cnt_r >= limit_i);
endmodule : msc_timer
`default_nettype wire

/* hw/msc_ctrl.sv */
// Contract
// - Four-sensor: mute only if A and B activate within pairing window.
// - Four-sensor: success needs all four sensors active together once.
// - Four-sensor: mute ends when C or D drops, or max mute time.
// - Four-sensor is bidirectional: D,C lead and B,A end.
// - Four-sensor needs no external enable input.
// - Four-sensor mutes primary curtain only; L-type may mute either or both.
// - L-type unidirectional: both sensors first, mute holds while curtain interrupted.
// - L-type: mute only if A and B activate within pairing window.
// - L-type ends on gap time exceeded, curtain clear, or max mute time.
// - Pairing window and gap time 50 ms..10 s, 0.05 s steps; 4 s, 5 s.
// - Max mute 0-63 s/min/h or 3 days, default 5 min.
// - Off-delay 0..2.55 s in 0.01 s steps, default 50 ms.
// - Override max 0..20 min in 5 s steps, default 5 s.
// - Mute-dependent override selectable, on by default.
// - L-type disable inputs, when enabled, must both be high to mute.
// - Off-delay applies to sensor inputs and curtain signal.
// - Override ends at its max time or when curtain clears.
// - After a disable drop, restart only after both disables were low.
// - With monitoring, gap time bounds mute-to-interrupt and clear-to-end.
`timescale 1ns/1ns
`default_nettype none
module msc_ctrl
   import msc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        mute_sensor_a_i,
   input  wire logic        mute_sensor_b_i,
   input  wire logic        mute_sensor_c_i,
   input  wire logic        mute_sensor_d_i,
   input  wire logic        curtain_blocked_i,
   input  wire logic        curtain2_blocked_i,
   input  wire logic        disable_a_i,
   input  wire logic        disable_b_i,
   input  wire logic        start_btn_i,
   output logic             mute_primary_o,
   output logic             mute_secondary_o,
   output logic             override_o,
   output logic             safety_out_o,
   output logic             timeout_o
);
   typedef enum logic [2:0] {MSC_IDLE, MSC_PAIR, MSC_MUTE, MSC_LOCK} msc_state_e;

   // Registers
   logic [5:0]  ctrl_r;
   logic [7:0]  tsens_r, tespe_r, tdel_r, tmdo_r;
   logic [9:0]  tmute_r;
   logic        ack_r;
   logic [31:0] rdat_r;
   msc_state_e  state_r;
   logic        rev_r, all4_r, ovr_r, dis_arm_r, ok_r, seen_int_r, tout_r;

   // Base tick divider
   logic [$clog2(TICK_CYC)-1:0] div_r;
   wire tick = (div_r == ($clog2(TICK_CYC))'(TICK_CYC - 1));
   always_ff @(posedge clk_i) begin
      if (rst_i || tick)
         div_r <= '0;
      else
         div_r <= div_r + 1'b1;
   end

   // Off-delayed sensor and curtain levels
   logic [5:0] held;
   msc_offdelay #(.N(6)) u_del (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .tick_i  (tick),
      .delay_i (tdel_r),
      .raw_i   ({curtain2_blocked_i, curtain_blocked_i, mute_sensor_d_i,
                 mute_sensor_c_i, mute_sensor_b_i, mute_sensor_a_i}),
      .held_o  (held)
   );
   wire sa = held[0];
   wire sb = held[1];
   wire sc = held[2];
   wire sd = held[3];
   wire cur1 = held[4];
   wire cur2 = held[5];

   // Configuration decode
   wire mode_l   = ctrl_r[CTRL_MODE_BIT];
   wire ovr_en   = ctrl_r[CTRL_OVR_BIT];
   wire dis_en   = ctrl_r[CTRL_DIS_BIT] && mode_l;
   wire mon_en   = ctrl_r[CTRL_MON_BIT];
   wire mute_c1  = ctrl_r[CTRL_CUR_BIT] || !mode_l;
   wire mute_c2  = ctrl_r[CTRL_CUR2_BIT] && mode_l;
   wire cur_any  = (mute_c1 && cur1) || (mute_c2 && cur2);

   // Time limits in ticks
   wire [31:0] sens_lim = 32'(tsens_r) * STEP_50MS_TK;
   wire [31:0] espe_lim = 32'(tespe_r) * STEP_50MS_TK;
   wire [31:0] mdo_lim  = 32'(tmdo_r) * STEP_5S_TK;
   wire [31:0] unit_tk  = (tmute_r[TMUTE_UNIT_LSB +: 2] == 2'(MSC_U_SEC))  ? 32'(SEC_TK) :
                          (tmute_r[TMUTE_UNIT_LSB +: 2] == 2'(MSC_U_MIN))  ? 32'(MIN_TK) : 32'(HOUR_TK);
   wire [31:0] mute_lim = (tmute_r[TMUTE_UNIT_LSB +: 2] == 2'(MSC_U_3DAY)) ? 32'(DAYS3_TK)
                          : 32'(tmute_r[5:0]) * unit_tk;

   // Sequence decode; lead pair and trailing pair swap with direction
   wire lead1 = rev_r ? sd : sa;
   wire lead2 = rev_r ? sc : sb;
   wire trl1  = rev_r ? sb : sc;
   wire trl2  = rev_r ? sa : sd;
   wire any_lead_fwd = sa || sb;
   wire any_lead_rev = !mode_l && (sc || sd);
   wire pair_done = lead1 && lead2;
   wire dis_ok  = !dis_en || (disable_a_i && disable_b_i && dis_arm_r);

   // Timers
   logic sens_exp, mute_exp, espe_exp, mdo_exp;
   wire in_mute  = (state_r == MSC_MUTE);
   wire espe_run = in_mute && mon_en && (mode_l ? (!cur_any) : (!seen_int_r || !cur_any));
   msc_timer u_sens (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick), .run_i(state_r == MSC_PAIR),
                     .limit_i(sens_lim), .expired_o(sens_exp));
   msc_timer u_mute (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick), .run_i(in_mute),
                     .limit_i(mute_lim), .expired_o(mute_exp));
   msc_timer u_espe (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick), .run_i(espe_run),
                     .limit_i(espe_lim), .expired_o(espe_exp));
   msc_timer u_mdo  (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick), .run_i(ovr_r),
                     .limit_i(mdo_lim), .expired_o(mdo_exp));

   // Mute end conditions
   wire end_4s = !trl1 || !trl2 || (!lead1 && !lead2 && !trl1);
   wire end_l  = !cur_any && seen_int_r;
   wire end_any = mute_exp || espe_exp || !dis_ok || (mode_l ? end_l : (seen_int_r && end_4s));

   // Sequencer
   msc_state_e state_nxt;
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         MSC_IDLE: begin
            if ((any_lead_fwd || any_lead_rev) && dis_ok) begin
               state_nxt = MSC_PAIR;
            end
         end
         MSC_PAIR: begin
            if (pair_done && dis_ok) begin
               state_nxt = MSC_MUTE;
            end else if (sens_exp || !dis_ok) begin
               state_nxt = MSC_LOCK;
            end else if (!lead1 && !lead2) begin
               state_nxt = MSC_IDLE;
            end
         end
         MSC_MUTE: begin
            if (end_any) begin
               state_nxt = MSC_LOCK;
            end
         end
         MSC_LOCK: begin
            // Sensors must all clear before a new passage may start
            if (!sa && !sb && !sc && !sd) begin
               state_nxt = MSC_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= MSC_IDLE;
         rev_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (state_r == MSC_IDLE)
            rev_r <= !any_lead_fwd && any_lead_rev;
      end
   end

   // Passage bookkeeping
   always_ff @(posedge clk_i) begin
      if (rst_i || state_r != MSC_MUTE) begin
         all4_r     <= 1'b0;
         seen_int_r <= 1'b0;
      end else begin
         if (sa && sb && sc && sd)
            all4_r <= 1'b1;
         if (mode_l ? cur_any : (trl1 && trl2))
            seen_int_r <= 1'b1;
      end
   end

   // Result of last mute: success or timeout
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ok_r   <= 1'b0;
         tout_r <= 1'b0;
      end else if (in_mute && state_nxt == MSC_LOCK) begin
         ok_r   <= mode_l ? !mute_exp && !espe_exp : all4_r && !mute_exp;
         tout_r <= mute_exp;
      end
   end

   // Disable re-arm: both must have been low after a drop
   always_ff @(posedge clk_i) begin
      if (rst_i)
         dis_arm_r <= 1'b1;
      else if (!disable_a_i && !disable_b_i)
         dis_arm_r <= 1'b1;
      else if (!disable_a_i || !disable_b_i)
         dis_arm_r <= 1'b0;
   end

   // Manual override
   always_ff @(posedge clk_i) begin
      if (rst_i)
         ovr_r <= 1'b0;
      else if (ovr_r && (mdo_exp || !cur_any))
         ovr_r <= 1'b0;
      else if (ovr_en && start_btn_i && cur_any && !in_mute)
         ovr_r <= 1'b1;
   end

   // Outputs
   assign mute_primary_o   = in_mute && mute_c1;
   assign mute_secondary_o = in_mute && mute_c2;
   assign override_o       = ovr_r;
   assign timeout_o        = tout_r;
   wire c1_bad = cur1 && !(in_mute && mute_c1);
   wire c2_bad = cur2 && !(in_mute && mute_c2);
   assign safety_out_o = !((c1_bad || c2_bad) && !ovr_r);

   // Wishbone slave, one wait state
   wire req = wb_cyc_i && wb_stb_i && !ack_r;
   wire wr  = req && wb_we_i && wb_sel_i[0];
   wire wr1 = req && wb_we_i && wb_sel_i[1];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r  <= CTRL_RST;
         tsens_r <= TSENS_RST;
         tespe_r <= TESPE_RST;
         tmute_r <= TMUTE_RST;
         tdel_r  <= TDEL_RST;
         tmdo_r  <= TMDO_RST;
      end else begin
         if (wr && wb_adr_i == REG_CTRL)
            ctrl_r <= wb_dat_i[5:0];
         if (wr && wb_adr_i == REG_TSENS && wb_dat_i[7:0] != 8'h00 && wb_dat_i[7:0] <= 8'hC8)
            tsens_r <= wb_dat_i[7:0];
         if (wr && wb_adr_i == REG_TESPE && wb_dat_i[7:0] != 8'h00 && wb_dat_i[7:0] <= 8'hC8)
            tespe_r <= wb_dat_i[7:0];
         if (wr && wb_adr_i == REG_TMUTE)
            tmute_r[5:0] <= wb_dat_i[5:0];
         if (wr1 && wb_adr_i == REG_TMUTE)
            tmute_r[9:6] <= {wb_dat_i[9:8], 2'b00};
         if (wr && wb_adr_i == REG_TDEL)
            tdel_r <= wb_dat_i[7:0];
         if (wr && wb_adr_i == REG_TMDO && wb_dat_i[7:0] <= 8'hF0)
            tmdo_r <= wb_dat_i[7:0];
      end
   end

   wire [31:0] stat_word = {24'h0, tout_r, ok_r, ovr_r, dis_arm_r, rev_r, 1'b0, 2'(state_r)};
   wire [31:0] rd_mux =
      (wb_adr_i == REG_CTRL)  ? {26'h0, ctrl_r}  :
      (wb_adr_i == REG_TSENS) ? {24'h0, tsens_r} :
      (wb_adr_i == REG_TESPE) ? {24'h0, tespe_r} :
      (wb_adr_i == REG_TMUTE) ? {22'h0, tmute_r[9:8], 2'b00, tmute_r[5:0]} :
      (wb_adr_i == REG_TDEL)  ? {24'h0, tdel_r}  :
      (wb_adr_i == REG_TMDO)  ? {24'h0, tmdo_r}  :
      (wb_adr_i == REG_STAT)  ? stat_word : 32'h0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r  <= 1'b0;
         rdat_r <= 32'h0;
      end else begin
         ack_r  <= req;
         rdat_r <= rd_mux;
      end
   end
   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;
endmodule : msc_ctrl
`default_nettype wire

/* verif/msc_ctrl_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module msc_ctrl_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic mute_sensor_a_i,
   input wire logic mute_sensor_b_i,
   input wire logic mute_sensor_c_i,
   input wire logic mute_sensor_d_i,
   input wire logic curtain_blocked_i,
   input wire logic start_btn_i,
   input wire logic mute_primary_o,
   input wire logic mute_secondary_o,
   input wire logic override_o,
   input wire logic safety_out_o,
   input wire logic timeout_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   wire pair_ab = mute_sensor_a_i && mute_sensor_b_i;
   wire pair_cd = mute_sensor_c_i && mute_sensor_d_i;
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not answered");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
   reset_quiet_a: assert property ($fell(rst_i) |-> !(mute_primary_o || mute_secondary_o || override_o || timeout_o))
      else $error("outputs active after reset");
   // Three samples so a registered curtain path cannot trip it
   safety_off_a: assert property (curtain_blocked_i [*3] ##0 (!mute_primary_o && !override_o) |-> !safety_out_o)
      else $error("safety on with curtain blocked");
   pair_lead_a: assert property ($rose(mute_primary_o) |-> pair_ab || pair_cd)
      else $error("mute without a leading pair");
   sec_lead_a: assert property ($rose(mute_secondary_o) |-> pair_ab)
      else $error("secondary mute without both sensors");
   timeout_cause_a: assert property ($rose(timeout_o) |-> $past(mute_primary_o || mute_secondary_o))
      else $error("timeout outside a mute");
   ovr_start_a: assert property ($rose(override_o) |-> $past(start_btn_i) && !mute_primary_o)
      else $error("override without start button");
   cover property ($rose(mute_primary_o));
   cover property ($rose(mute_secondary_o));
   cover property ($rose(override_o));
endmodule : msc_ctrl_chk
bind msc_ctrl msc_ctrl_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .mute_sensor_a_i, .mute_sensor_b_i,
   .mute_sensor_c_i, .mute_sensor_d_i, .curtain_blocked_i, .start_btn_i, .mute_primary_o, .mute_secondary_o,
   .override_o, .safety_out_o, .timeout_o);
`default_nettype wire

/* verif/msc_field_model.sv */
`timescale 1ns/1ns
`default_nettype none
module msc_field_model (
   input  wire logic       dir_i,
   input  wire logic [2:0] step_i,
   input  wire logic       intrude_i,
   input  wire logic       two_i,
   input  wire logic       press_i,
   output logic      [3:0] sens_o,
   output logic            curt_o,
   output logic            curt2_o,
   output logic            start_o
);
   // Object position along the belt as {curtain, d, c, b, a}; lead sensors arrive one after another
   localparam logic [4:0] SCENE [8] = '{5'h00, 5'h01, 5'h03, 5'h13, 5'h1F, 5'h1C, 5'h0C, 5'h08};
   wire [4:0] now_w = SCENE[step_i];
   // Reverse travel mirrors the sensor row
   assign sens_o  = dir_i ? {now_w[0], now_w[1], now_w[2], now_w[3]} : now_w[3:0];
   assign curt_o  = now_w[4] | intrude_i;
   assign curt2_o = now_w[4] & two_i;
   assign start_o = press_i;
endmodule : msc_field_model
`default_nettype wire

/* verif/muting_sequence_ctrl_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module muting_sequence_ctrl_bench;
   import msc_pkg::*;
   localparam logic [7:0]  RA [6] = '{REG_CTRL, REG_TSENS, REG_TESPE, REG_TMUTE, REG_TDEL, REG_TMDO};
   localparam logic [31:0] RV [6] = '{32'(CTRL_RST), 32'(TSENS_RST), 32'(TESPE_RST), 32'(TMUTE_RST),
                                      32'(TDEL_RST), 32'(TMDO_RST)};
   logic        clk_i, rst_i, req, we, dir, intr, press, two, dis_a, dis_b;
   logic [2:0]  step;
   logic [7:0]  adr;
   logic [31:0] wdat, rdat, rd, v;
   logic [3:0]  sens;
   logic        ack, mp, ms, ovr, safe, tmo, curt, curt2, start;
   int          errors, num_checks;

   msc_field_model u_field (.dir_i(dir), .step_i(step), .intrude_i(intr), .two_i(two), .press_i(press),
      .sens_o(sens), .curt_o(curt), .curt2_o(curt2), .start_o(start));
   msc_ctrl dut (.clk_i, .rst_i, .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack), .mute_sensor_a_i(sens[0]), .mute_sensor_b_i(sens[1]),
      .mute_sensor_c_i(sens[2]), .mute_sensor_d_i(sens[3]), .curtain_blocked_i(curt), .curtain2_blocked_i(curt2),
      .disable_a_i(dis_a), .disable_b_i(dis_b), .start_btn_i(start), .mute_primary_o(mp),
      .mute_secondary_o(ms), .override_o(ovr), .safety_out_o(safe), .timeout_o(tmo));

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Cycle held until ack; the master never assumes a latency
   // Only the watchdog ends a wait that never sees ack
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      req <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rd = rdat;
      req <= 1'b0;
   endtask : bus

   task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
      bus(1'b1, a, d);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : wr_rd

   function automatic logic outv(input int w);
      case (w)
         0: return mp;
         1: return ms;
         2: return ovr;
         3: return safe;
         default: return tmo;
      endcase
   endfunction : outv

   task automatic expect_out(input int w, input logic e);
      int n;
      n = 0;
      while (outv(w) !== e && n < 16) begin
         @(negedge clk_i);
         n++;
      end
      chk({31'h0, outv(w)}, {31'h0, e});
   endtask : expect_out

   task automatic go(input int s);
      @(posedge clk_i);
      step <= 3'(s);
      repeat ($urandom_range(4, 2)) @(posedge clk_i);
   endtask : go

   // L-type drops at curtain clear, four-sensor only when the trailing pair breaks
   function automatic logic exp_mute(input logic lt, input int s);
      return (s >= 2) && (s <= (lt ? 5 : 6));
   endfunction : exp_mute

   task automatic pass(input logic d, input logic lt);
      @(posedge clk_i);
      dir <= d;
      two <= lt;
      for (int s = 0; s < 8; s++) begin
         go(s);
         expect_out(0, exp_mute(lt, s));
         expect_out(1, lt & exp_mute(lt, s));
         expect_out(3, 1'b1);
      end
      go(0);
   endtask : pass

   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      $display("watchdog expired");
      summarize();
   end

   initial begin
      void'($urandom(32'h1D65D01C));
      {rst_i, req, we, dir, intr, press, two, dis_a, dis_b} = 9'h100;
      step = 3'h0;
      adr = 8'h00;
      wdat = 32'h0;
      errors = 0;
      num_checks = 0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (RA[i]) begin
         bus(1'b0, RA[i], 32'h0);
         chk(rd, RV[i]);
      end
      bus(1'b0, 8'h1C, 32'h0);
      chk(rd, 32'h0);
      wr_rd(REG_TSENS, 32'h0, 32'h50);
      wr_rd(REG_TSENS, 32'hC9, 32'h50);
      wr_rd(REG_TSENS, 32'hC8, 32'hC8);
      wr_rd(REG_TSENS, 32'h50, 32'h50);
      wr_rd(REG_TMDO, 32'hF1, 32'h1);
      wr_rd(REG_TMDO, 32'hF0, 32'hF0);
      wr_rd(REG_TMUTE, 32'h33F, 32'h33F);
      wr_rd(REG_TDEL, 32'hFF, 32'hFF);
      wr_rd(REG_TDEL, 32'h0, 32'h0);
      repeat (3) begin
         v = $urandom_range(200, 1);
         wr_rd(REG_TESPE, v, v);
      end
      $display("register test done");
      pass(1'b0, 1'b0);
      pass(1'b1, 1'b0);
      bus(1'b1, REG_CTRL, 32'h3B);
      pass(1'b0, 1'b1);
      $display("sequence test done");
      bus(1'b1, REG_CTRL, 32'h3F);
      go(2);
      expect_out(0, 1'b0);
      go(0);
      {dis_a, dis_b} <= 2'b11;
      go(2);
      expect_out(0, 1'b1);
      @(posedge clk_i);
      dis_a <= 1'b0;
      expect_out(0, 1'b0);
      @(posedge clk_i);
      dis_a <= 1'b1;
      go(0);
      go(2);
      expect_out(0, 1'b0);
      go(0);
      {dis_a, dis_b} <= 2'b00;
      go(0);
      {dis_a, dis_b} <= 2'b11;
      go(2);
      expect_out(0, 1'b1);
      go(3);
      go(6);
      expect_out(0, 1'b0);
      go(0);
      $display("disable test done");
      bus(1'b1, REG_CTRL, 32'h1A);
      @(posedge clk_i);
      intr <= 1'b1;
      expect_out(3, 1'b0);
      @(posedge clk_i);
      press <= 1'b1;
      expect_out(2, 1'b1);
      expect_out(3, 1'b1);
      @(posedge clk_i);
      intr <= 1'b0;
      expect_out(2, 1'b0);
      @(posedge clk_i);
      press <= 1'b0;
      bus(1'b1, REG_CTRL, 32'h18);
      @(posedge clk_i);
      {intr, press} <= 2'b11;
      repeat (16) @(posedge clk_i);
      expect_out(2, 1'b0);
      expect_out(3, 1'b0);
      @(posedge clk_i);
      {intr, press} <= 2'b00;
      $display("override test done");
      // Zero seconds of mute time: the sequence times out at once
      bus(1'b1, REG_TMUTE, 32'h0);
      go(2);
      expect_out(4, 1'b1);
      expect_out(0, 1'b0);
      go(0);
      bus(1'b0, REG_STAT, 32'h0);
      chk(rd, 32'h90);
      $display("timeout test done");
      summarize();
   end
endmodule : muting_sequence_ctrl_bench
`default_nettype wire
